//--- design/ttm_timer.sv
// Purpose: host port and programming logic of a three-channel interval timer
// Assumes: all pins synchronous to core_clk; strobes last at least two cycles
// Notes:   count clocks are sampled; one count per rising edge seen
`timescale 1ns/1ps
`include "ttm_regs.svh"
module ttm_timer (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [1:0] register_select_pins,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   input  wire logic [2:0] count_clock_inputs,
   input  wire logic [2:0] count_enable_inputs,
   output logic      [2:0] counter_waveform_pins
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   ttm_pkg::ttm_mode_t  mode_reg [3], mode_next [3];
   ttm_pkg::ttm_fmt_t   fmt_reg [3], fmt_next [3];
   ttm_pkg::ttm_count_t reload_reg [3], reload_next [3];
   ttm_pkg::ttm_count_t latch_reg [3], latch_next [3];
   ttm_pkg::ttm_count_t cnt_w [3];
   logic [7:0] lsb_reg [3], lsb_next [3];
   logic [2:0] bcd_reg, bcd_next;
   logic [2:0] wr_hi_reg, wr_hi_next;
   logic [2:0] rd_hi_reg, rd_hi_next;
   logic [2:0] latched_reg, latched_next;
   logic [2:0] cclk_reg, tick;
   logic [2:0] cfg_wr, load, hold;
   logic [7:0] data_out_next;
   logic       data_oe_next;
   logic       wr_prev_reg, rd_prev_reg;
   logic       wr_ev, rd_end, ctrl_ev, rd_act;
   logic [1:0] sel;
   ttm_pkg::ttm_count_t rd_val;
   ttm_pkg::ttm_mode_t  cw_mode;

   // a strobe acts once, on its leading edge for writes and trailing edge for reads
   assign wr_ev   = !cs_n && rd_n && !wr_n && wr_prev_reg;
   assign rd_end  = !cs_n && wr_n && rd_n && !rd_prev_reg;
   assign rd_act  = !cs_n && !rd_n && wr_n;
   assign ctrl_ev = wr_ev && register_select_pins == `TTM_OFS_SETUP;
   assign sel     = data_in[`TTM_SEL_HI:`TTM_SEL_LO];
   assign tick    = count_clock_inputs & ~cclk_reg;
   // middle mode bit set means mode 2 or 3 whatever the top bit says
   assign cw_mode = data_in[`TTM_MODE_B1] ?
                    {1'b0, data_in[`TTM_MODE_B1], data_in[`TTM_MODE_B0]} :
                    data_in[`TTM_MODE_B2:`TTM_MODE_B0];
   assign rd_val  = latched_reg[register_select_pins] ? latch_reg[register_select_pins]
                                                      : cnt_w[register_select_pins];

   // ---------------------------------------------
   // host port decode
   // ---------------------------------------------
   always_comb begin
      mode_next    = mode_reg;
      fmt_next     = fmt_reg;
      reload_next  = reload_reg;
      latch_next   = latch_reg;
      lsb_next     = lsb_reg;
      bcd_next     = bcd_reg;
      wr_hi_next   = wr_hi_reg;
      rd_hi_next   = rd_hi_reg;
      latched_next = latched_reg;
      cfg_wr       = 3'h0;
      load         = 3'h0;
      hold         = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (ctrl_ev && sel == i[1:0]) begin
            if (data_in[`TTM_FMT_HI:`TTM_FMT_LO] == `TTM_FMT_LATCH) begin
               if (!latched_reg[i]) begin
                  latch_next[i]   = cnt_w[i];
                  latched_next[i] = 1'b1;
               end
            end else begin
               fmt_next[i]     = data_in[`TTM_FMT_HI:`TTM_FMT_LO];
               mode_next[i]    = cw_mode;
               bcd_next[i]     = data_in[`TTM_BCD_BIT];
               wr_hi_next[i]   = 1'b0;
               rd_hi_next[i]   = 1'b0;
               latched_next[i] = 1'b0;
               cfg_wr[i]       = 1'b1;
            end
         end
         if (wr_ev && register_select_pins == i[1:0]) begin
            case (fmt_reg[i])
               `TTM_FMT_LSB: begin
                  reload_next[i] = {8'h00, data_in};
                  load[i]        = 1'b1;
               end
               `TTM_FMT_MSB: begin
                  reload_next[i] = {data_in, 8'h00};
                  load[i]        = 1'b1;
               end
               `TTM_FMT_BOTH: begin
                  if (!wr_hi_reg[i]) begin
                     lsb_next[i]   = data_in;
                     wr_hi_next[i] = 1'b1;
                     hold[i]       = 1'b1;
                  end else begin
                     reload_next[i] = {data_in, lsb_reg[i]};
                     wr_hi_next[i]  = 1'b0;
                     load[i]        = 1'b1;
                  end
               end
               default: begin
                  load[i] = 1'b0;
               end
            endcase
         end
         if (rd_end && register_select_pins == i[1:0]) begin
            if (fmt_reg[i] == `TTM_FMT_BOTH) begin
               rd_hi_next[i] = ~rd_hi_reg[i];
            end
            if (fmt_reg[i] != `TTM_FMT_BOTH || rd_hi_reg[i]) begin
               latched_next[i] = 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------
   // read data and drive enable
   // ---------------------------------------------
   always_comb begin
      data_out_next = 8'h00;
      data_oe_next  = rd_act && register_select_pins != `TTM_OFS_SETUP;
      if (data_oe_next) begin
         if (fmt_reg[register_select_pins] == `TTM_FMT_MSB ||
             (fmt_reg[register_select_pins] == `TTM_FMT_BOTH && rd_hi_reg[register_select_pins])) begin
            data_out_next = rd_val[15:8];
         end else begin
            data_out_next = rd_val[7:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 3; i++) begin
            mode_reg[i]   <= `TTM_RST_MODE;
            fmt_reg[i]    <= `TTM_RST_FMT;
            reload_reg[i] <= `TTM_RST_CNT;
            latch_reg[i]  <= `TTM_RST_CNT;
            lsb_reg[i]    <= 8'h00;
         end
         bcd_reg     <= 3'h0;
         wr_hi_reg   <= 3'h0;
         rd_hi_reg   <= 3'h0;
         latched_reg <= 3'h0;
         cclk_reg    <= 3'h0;
         wr_prev_reg <= 1'b1;
         rd_prev_reg <= 1'b1;
         data_out    <= 8'h00;
         data_oe     <= 1'b0;
      end else begin
         mode_reg    <= mode_next;
         fmt_reg     <= fmt_next;
         reload_reg  <= reload_next;
         latch_reg   <= latch_next;
         lsb_reg     <= lsb_next;
         bcd_reg     <= bcd_next;
         wr_hi_reg   <= wr_hi_next;
         rd_hi_reg   <= rd_hi_next;
         latched_reg <= latched_next;
         cclk_reg    <= count_clock_inputs;
         wr_prev_reg <= wr_n;
         rd_prev_reg <= rd_n;
         data_out    <= data_out_next;
         data_oe     <= data_oe_next;
      end
   end

   // ---------------------------------------------
   // counters
   // ---------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_ch
      ttm_channel u_ch (
         .core_clk (core_clk),
         .sys_rst  (sys_rst),
         .tick     (tick[g]),
         .gate     (count_enable_inputs[g]),
         .cfg_wr   (cfg_wr[g]),
         // the setup cycle already sees the new mode, so the output level follows the word being written
         .mode     (mode_next[g]),
         .bcd      (bcd_reg[g]),
         .load     (load[g]),
         .hold     (hold[g]),
         .reload   (reload_reg[g]),
         .count    (cnt_w[g]),
         .wave     (counter_waveform_pins[g])
      );
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   float_cs_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      cs_n |=> !data_oe) else $error("port driven while deselected");
   float_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      !cs_n && rd_n && wr_n |=> !data_oe) else $error("port driven with no strobe");
   read_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      rd_act && register_select_pins != `TTM_OFS_SETUP |=> data_oe) else $error("read not driven");
   read_setup_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      rd_act && register_select_pins == `TTM_OFS_SETUP |=> !data_oe) else $error("setup offset driven");
   deselect_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      cs_n |=> $stable(fmt_reg[0]) && $stable(reload_reg[0]) && $stable(latched_reg))
      else $error("state changed while deselected");
   illegal_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_ev && sel == `TTM_SEL_ILLEGAL |=> $stable(mode_reg[2]) && $stable(fmt_reg[2])
      && $stable(bcd_reg)) else $error("illegal select changed setup");
   low_first_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_ev && sel == 2'h1 && data_in[`TTM_FMT_HI:`TTM_FMT_LO] != `TTM_FMT_LATCH
      |=> !wr_hi_reg[1] ##1 !wr_hi_reg[1] || !cs_n) else $error("byte pointer not reset");
   latch_copy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_ev && sel == 2'h1 && data_in[`TTM_FMT_HI:`TTM_FMT_LO] == `TTM_FMT_LATCH && !latched_reg[1]
      |=> latched_reg[1] && latch_reg[1] == $past(cnt_w[1])) else $error("latch missed count");
   lsb_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_ev && register_select_pins == 2'h2 && fmt_reg[2] == `TTM_FMT_LSB
      |=> reload_reg[2] == {8'h00, $past(data_in)}) else $error("low byte not loaded");
   word_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_ev && register_select_pins == 2'h2 && fmt_reg[2] == `TTM_FMT_BOTH && wr_hi_reg[2]
      |=> reload_reg[2] == {$past(data_in), $past(lsb_reg[2])}) else $error("word not assembled");
   mode_fold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_ev && sel == 2'h2 && data_in[`TTM_FMT_HI:`TTM_FMT_LO] != `TTM_FMT_LATCH
      && data_in[`TTM_MODE_B2:`TTM_MODE_B0] == 3'h6 |=> mode_reg[2] == `TTM_MODE2)
      else $error("mode top bit not ignored");
   word_cov_c: cover property (@(posedge core_clk) disable iff (sys_rst)
      load[2] && fmt_reg[2] == `TTM_FMT_BOTH);
   latch_cov_c: cover property (@(posedge core_clk) disable iff (sys_rst)
      latched_reg[1] ##[1:50] rd_end && !latched_next[1]);
   read_cov_c: cover property (@(posedge core_clk) disable iff (sys_rst)
      data_oe && register_select_pins == 2'h0);
endmodule

//--- design/ttm_regs.svh
// Purpose: offsets, field positions, codes and reset values of the triple timer
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef TTM_REGS_SVH
`define TTM_REGS_SVH
// ---------------------------------------------
// port offsets on register_select_pins
// ---------------------------------------------
`define TTM_OFS_CNT0     2'h0
`define TTM_OFS_CNT1     2'h1
`define TTM_OFS_CNT2     2'h2
`define TTM_OFS_SETUP    2'h3
// ---------------------------------------------
// channel_setup_word fields
// ---------------------------------------------
`define TTM_SEL_HI       7
`define TTM_SEL_LO       6
`define TTM_FMT_HI       5
`define TTM_FMT_LO       4
`define TTM_MODE_B2      3
`define TTM_MODE_B1      2
`define TTM_MODE_B0      1
`define TTM_BCD_BIT      0
`define TTM_SEL_ILLEGAL  2'h3
`define TTM_FMT_LATCH    2'h0
`define TTM_FMT_LSB      2'h1
`define TTM_FMT_MSB      2'h2
`define TTM_FMT_BOTH     2'h3
`define TTM_MODE0        3'h0
`define TTM_MODE1        3'h1
`define TTM_MODE2        3'h2
`define TTM_MODE3        3'h3
`define TTM_MODE4        3'h4
`define TTM_MODE5        3'h5
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define TTM_RST_MODE     3'h0
`define TTM_RST_FMT      2'h3
`define TTM_RST_CNT      16'h0000
`define TTM_RST_WAVE     1'b0
`endif

//--- design/ttm_pkg.sv
// Purpose: shared types of the triple timer
// Assumes: nothing
// Notes:   numbers live in ttm_regs.svh
package ttm_pkg;
   typedef enum logic [1:0] {TTM_IDLE, TTM_ARMED, TTM_RUN} ttm_phase_e;
   typedef logic [15:0] ttm_count_t;
   typedef logic [2:0]  ttm_mode_t;
   typedef logic [1:0]  ttm_fmt_t;
endpackage

//--- design/ttm_channel.sv
// Purpose: one 16-bit down-counter with its six waveform modes
// Assumes: tick is a one-cycle pulse per rising edge of the count clock
// Notes:   gate edges are remembered until the next tick
`timescale 1ns/1ps
`include "ttm_regs.svh"
module ttm_channel (
   input  wire logic            core_clk,
   input  wire logic            sys_rst,
   input  wire logic            tick,
   input  wire logic            gate,
   input  wire logic            cfg_wr,
   input  wire ttm_pkg::ttm_mode_t mode,
   input  wire logic            bcd,
   input  wire logic            load,
   input  wire logic            hold,
   input  wire ttm_pkg::ttm_count_t reload,
   output ttm_pkg::ttm_count_t  count,
   output logic                 wave
);
   ttm_pkg::ttm_phase_e phase_reg, phase_next;
   ttm_pkg::ttm_count_t cnt_reg, cnt_next;
   logic wave_reg, wave_next, gate_reg, trig_reg, trig_next;
   logic hw_trig, m23;

   // binary or four-decade decrement; zero wraps, giving a full count
   function automatic ttm_pkg::ttm_count_t dec(input ttm_pkg::ttm_count_t v, input logic b);
      ttm_pkg::ttm_count_t r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!b) begin
         r = v - 16'h0001;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (borrow) begin
               if (v[k*4 +: 4] == 4'h0) begin
                  r[k*4 +: 4] = 4'h9;
               end else begin
                  r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   assign hw_trig = (mode == `TTM_MODE1) || (mode == `TTM_MODE5);
   assign m23     = (mode == `TTM_MODE2) || (mode == `TTM_MODE3);
   assign count   = cnt_reg;
   assign wave    = wave_reg;

   // ---------------------------------------------
   // counting
   // ---------------------------------------------
   always_comb begin
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      wave_next  = wave_reg;
      trig_next  = trig_reg | (gate & ~gate_reg);
      if (cfg_wr) begin
         cnt_next   = `TTM_RST_CNT;
         wave_next  = (mode != `TTM_MODE0);
         phase_next = ttm_pkg::TTM_IDLE;
         trig_next  = 1'b0;
      end else begin
         if (load && (!m23 || phase_reg != ttm_pkg::TTM_RUN) && !(hw_trig && phase_reg == ttm_pkg::TTM_RUN)) begin
            phase_next = ttm_pkg::TTM_ARMED;
         end
         if (load && (mode == `TTM_MODE0 || mode == `TTM_MODE4)) begin
            phase_next = ttm_pkg::TTM_ARMED;
         end
         if (hold && mode == `TTM_MODE0) begin
            phase_next = ttm_pkg::TTM_IDLE;
         end
         if (m23 && !gate) begin
            wave_next = 1'b1;
            if (phase_reg == ttm_pkg::TTM_RUN) begin
               phase_next = ttm_pkg::TTM_ARMED;
            end
         end
         if (tick && phase_next == phase_reg) begin
            trig_next = 1'b0;
            case (phase_reg)
               ttm_pkg::TTM_ARMED: begin
                  if ((!hw_trig || trig_reg) && (!m23 || gate)) begin
                     cnt_next   = reload;
                     phase_next = ttm_pkg::TTM_RUN;
                     wave_next  = !(mode == `TTM_MODE0 || mode == `TTM_MODE1);
                  end
               end
               ttm_pkg::TTM_RUN: begin
                  if (trig_reg && (hw_trig || mode == `TTM_MODE4)) begin
                     cnt_next  = reload;
                     wave_next = (mode != `TTM_MODE1);
                  end else if (gate || hw_trig) begin
                     cnt_next = dec(cnt_reg, bcd);
                     case (mode)
                        `TTM_MODE0: begin
                           if (cnt_reg == 16'h0001) wave_next = 1'b1;
                        end
                        `TTM_MODE1: begin
                           if (cnt_reg == 16'h0001) begin
                              wave_next  = 1'b1;
                              phase_next = ttm_pkg::TTM_ARMED;
                           end
                        end
                        `TTM_MODE2: begin
                           wave_next = (cnt_reg != 16'h0002);
                           if (cnt_reg == 16'h0001) cnt_next = reload;
                        end
                        `TTM_MODE3: begin
                           // two steps per tick; odd counts give the longer half to the high level
                           cnt_next = dec(dec(cnt_reg, bcd), bcd);
                           if (cnt_reg == 16'h0002 || (wave_reg && cnt_reg == 16'h0001)) begin
                              wave_next = ~wave_reg;
                              cnt_next  = (wave_reg && reload[0]) ? dec(reload, bcd) : reload;
                           end
                        end
                        default: begin
                           wave_next = (cnt_reg != 16'h0001);
                           if (cnt_reg == 16'h0001) phase_next = hw_trig ? ttm_pkg::TTM_ARMED : ttm_pkg::TTM_IDLE;
                        end
                     endcase
                  end
               end
               default: begin
                  if (mode == `TTM_MODE4 || mode == `TTM_MODE5) wave_next = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase_reg <= ttm_pkg::TTM_IDLE;
         cnt_reg   <= `TTM_RST_CNT;
         wave_reg  <= `TTM_RST_WAVE;
         gate_reg  <= 1'b0;
         trig_reg  <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         cnt_reg   <= cnt_next;
         wave_reg  <= wave_next;
         gate_reg  <= gate;
         trig_reg  <= trig_next;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   cfg_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      cfg_wr |=> cnt_reg == 16'h0000) else $error("count not cleared by setup");
   mode0_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      cfg_wr && mode == `TTM_MODE0 |=> !wave_reg) else $error("mode 0 output not low");
   gate_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      phase_reg == ttm_pkg::TTM_RUN && mode == `TTM_MODE0 && !gate && !cfg_wr && !trig_reg
      |=> $stable(cnt_reg)) else $error("counted with gate low");
   gate_force_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      m23 && !gate && !cfg_wr |=> wave_reg) else $error("output not forced high");
   run_cov_c: cover property (@(posedge core_clk) disable iff (sys_rst)
      phase_reg == ttm_pkg::TTM_RUN && mode == `TTM_MODE3 && $changed(wave_reg));
endmodule

//--- dv/ttm_host_model.sv
// Purpose: host side of the timer bus
// Assumes: strobes held two core cycles, select held one cycle past the strobe
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
module ttm_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic [1:0]      register_select_pins,
   output logic [7:0]      data_in
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      register_select_pins = 2'h0;
      data_in = 8'h00;
   end
   // one access; read data taken at the edge that ends the strobe
   // select stays low one cycle after the strobe so the read pointer sees its trailing edge
   task automatic acc(input logic n, input logic r, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(posedge core_clk);
      #1;
      cs_n = n;
      rd_n = !r;
      wr_n = r;
      register_select_pins = a;
      data_in = d;
      repeat (2) @(posedge core_clk);
      q = data_out;
      oe = data_oe;
      #1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = ~d;
      @(posedge core_clk);
      #1;
      cs_n = 1'b1;
   endtask
endmodule

//--- dv/triple_timer_host_programming_tb.sv
// Purpose: self-checking bench of the timer host port
// Assumes: count clocks move only through the pulse task
// Notes:   counts kept in a small model array
`timescale 1ns/1ps
module triple_timer_host_programming_tb;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [2:0]  cclk = 3'h0;
   logic [2:0]  gate = 3'h7;
   logic [2:0]  wave;
   logic [7:0]  dout;
   logic [7:0]  din;
   logic [7:0]  q;
   logic [1:0]  a;
   logic        oe, oe_s, cs_n, rd_n, wr_n;
   logic [15:0] v;
   logic [15:0] exp_cnt [3];
   integer      errors = 0, comparisons = 0, seed = 19;
   always #20 core_clk = ~core_clk;
   ttm_timer i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .register_select_pins(a), .data_in(din), .data_out(dout), .data_oe(oe),
      .count_clock_inputs(cclk), .count_enable_inputs(gate), .counter_waveform_pins(wave));
   ttm_host_model i_host (.core_clk(core_clk), .data_out(dout), .data_oe(oe), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .register_select_pins(a), .data_in(din));
   // ---------------------------------------------
   // checking
   // ---------------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] expv);
      comparisons++;
      if (seen !== expv) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task print_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task wr(input logic [1:0] ad, input logic [7:0] d);
      i_host.acc(1'b0, 1'b0, ad, d, q, oe_s);
   endtask
   task rd(input logic [1:0] ad, input logic [7:0] e);
      i_host.acc(1'b0, 1'b1, ad, 8'h00, q, oe_s);
      check({oe_s, q}, {1'b1, e});
   endtask
   // n rising edges on the count clocks in mask m, each high two cycles and low one
   task pulse(input logic [2:0] m, input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         cclk = m;
         repeat (2) @(posedge core_clk);
         #1;
         cclk = 3'h0;
      end
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      check({oe, wave}, 16'h0000);
      for (int ch = 0; ch < 3; ch++) begin
         v = 16'($random(seed)) | 16'h8000;
         exp_cnt[ch] = v;
         wr(2'h3, {2'(ch), 6'h30});
         wr(2'(ch), v[7:0]);
         wr(2'(ch), v[15:8]);
      end
      check(wave, 3'h0);
      // the written count reaches each counter at its first count clock
      pulse(3'h7, 1);
      for (int ch = 0; ch < 3; ch++) begin
         rd(2'(ch), exp_cnt[ch][7:0]);
         rd(2'(ch), exp_cnt[ch][15:8]);
      end
      // deselected and illegal accesses must leave everything alone
      i_host.acc(1'b1, 1'b0, 2'h0, 8'h55, q, oe_s);
      i_host.acc(1'b1, 1'b1, 2'h0, 8'h00, q, oe_s);
      check(oe_s, 1'b0);
      wr(2'h3, 8'hf0);
      rd(2'h0, exp_cnt[0][7:0]);
      rd(2'h0, exp_cnt[0][15:8]);
      i_host.acc(1'b0, 1'b1, 2'h3, 8'h00, q, oe_s);
      check(oe_s, 1'b0);
      // latched value survives count clocks
      wr(2'h3, 8'h40);
      pulse(3'h2, 4);
      rd(2'h1, exp_cnt[1][7:0]);
      rd(2'h1, exp_cnt[1][15:8]);
      // once the latch is read out the live count shows the four steps
      exp_cnt[1] = exp_cnt[1] - 16'h0004;
      rd(2'h1, exp_cnt[1][7:0]);
      rd(2'h1, exp_cnt[1][15:8]);
      // a low gate suspends a mode 0 count, a high one resumes it
      gate = 3'h6;
      pulse(3'h1, 2);
      rd(2'h0, exp_cnt[0][7:0]);
      rd(2'h0, exp_cnt[0][15:8]);
      gate = 3'h7;
      pulse(3'h1, 1);
      exp_cnt[0] = exp_cnt[0] - 16'h0001;
      rd(2'h0, exp_cnt[0][7:0]);
      rd(2'h0, exp_cnt[0][15:8]);
      // mode 2 with the top mode bit set idles high
      wr(2'h3, 8'h9c);
      repeat (3) @(posedge core_clk);
      check(wave[2], 1'b1);
      wr(2'h2, 8'h05);
      pulse(3'h4, 1);
      rd(2'h2, 8'h05);
      gate = 3'h3;
      repeat (2) @(posedge core_clk);
      #1;
      check(wave[2], 1'b1);
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      errors++;
      print_verdict;
   end
endmodule
